//--- include/soak_program_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the soak program sequencer.
 Included by the design file; holds definitions only.
*/
`ifndef SOAK_PROGRAM_REGS_SVH
`define SOAK_PROGRAM_REGS_SVH

// ==========================================================================
// Register offsets (word addresses on the plain register port)
`define REG_PATTERN 4'h0
`define REG_START 4'h1
`define REG_SOAK 4'h2
`define REG_UNIT 4'h3
`define REG_BAND 4'h4
`define REG_PROCESS 4'h5
`define REG_ASSIGN 4'h6
`define REG_STATUS 4'h7
`define REG_REMAIN 4'h8
`define REG_WRITES 4'h9

// ==========================================================================
// Reset values and limits
`define SOAK_MIN 14'h0001
`define SOAK_MAX 14'h270F
`define SOAK_RESET 14'h0001
`define BAND_MIN 14'h0001
`define BAND_MAX 14'h270F
`define BAND_RESET 14'h0000

// ==========================================================================
// Status bit positions
`define ST_RUN 0
`define ST_END 1
`define ST_ACTIVE 2
`define ST_BLINK 3

// ==========================================================================
// Timing: clock rate and 0.5 s blink, 1 s tick
`define CLK_HZ 125000000
`define BLINK_MS 500
`define BLINK_CYCLES (`CLK_HZ / 1000 * `BLINK_MS)
`define SECOND_CYCLES `CLK_HZ
`define SECONDS_PER_MIN 60
`define SECONDS_PER_HOUR 3600

`endif

//--- include/soak_program_pkg.sv
/*
 Types of the soak program sequencer.
 Assumes nothing of its surroundings.
*/
package soak_program_pkg;

	typedef enum logic [1:0] {
		PATTERN_OFF,
		PATTERN_STOP,
		PATTERN_KEEP
	} program_pattern_select_t;

	typedef enum logic [1:0] {
		UNIT_SECONDS,
		UNIT_MINUTES,
		UNIT_HOURS
	} soak_unit_t;

	typedef enum logic [1:0] {
		OUT_NONE,
		OUT_END,
		OUT_FIRST_ALARM,
		OUT_COOLING
	} out_function_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_SOAK,
		SEQ_DONE
	} seq_state_t;

endpackage

//--- hw/soak_program_sequencer.sv
/*
 Soak program sequencer: a single-step program that times in-band soak and raises program end.
 Assumes one 125 MHz clock, registers reached over a plain address/strobe port, and event
 inputs and the communications command arriving from outside the clock domain.
*/
// Behaviour
// R1 - A start setting change from idle to go begins a program run.
// R2 - Accumulated in-band time reaching soak time raises program end output and indication.
// R3 - Pattern off means no program operation whatever start requests arrive.
// R4 - Stop pattern halts control, run switches to stop at program end.
// R5 - Keep-running pattern stays in run after program end.
// R6 - Soak duration accepts 1 to 9999 in seconds, minutes or hours; default 1.
// R7 - Soak timer advances only inside set point plus or minus band; holds outside.
// R8 - Band off means unbounded band: timer counts continuously from start.
// R9 - Start by setting, by assigned event input, or by command if no event assigned.
// R10 - Event-assigned start makes start setting a read-only monitor of the event.
// R11 - Pattern set to off resets event assignment of program start to none.
// R12 - At end, primary shows process value; secondary alternates set point and end each 0.5 s.
// R13 - Pattern off to on routes end function to auxiliary output 1 unless cooling has it.
// R14 - Pattern on to off restores the first alarm output to its alarm function.
// R15 - Start setting go to idle clears program end output and indication.
// R16 - An event input also clears end; start setting cannot clear it when event-assigned.
// R17 - Every start and reset requests a non-volatile memory write.
// R18 - Band for analog variants is off or 0.01 to 99.99 percent of full scale.
// R19 - Program end is assignable to any output and reported in communications status.
// R20 - Remaining monitor is soak duration minus elapsed, clamped to zero through duration.
`include "soak_program_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module soak_program_sequencer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Process values, same clock domain
	input wire logic [15:0] process_value,
	input wire logic [15:0] set_point,
	input wire logic cooling_on_aux1,
	// Asynchronous requests
	input wire logic event_start_pin,
	input wire logic event_clear_pin,
	input wire logic comm_start_pin,
	// Outputs
	output logic aux_out1,
	output logic alarm_out1,
	output logic run_mode,
	output logic end_indication,
	output logic show_end_on_secondary,
	output logic nvm_write_req
);

	localparam logic [26:0] BLINK_LAST = 27'(`BLINK_CYCLES - 1);
	localparam logic [26:0] SECOND_LAST = 27'(`SECOND_CYCLES - 1);

	typedef struct packed {
		logic [2:0] ev_start_s;
		logic [2:0] ev_clear_s;
		logic [2:0] comm_s;
		soak_program_pkg::program_pattern_select_t pattern;
		soak_program_pkg::soak_unit_t unit;
		soak_program_pkg::seq_state_t seq;
		soak_program_pkg::out_function_t aux1_fn;
		soak_program_pkg::out_function_t alarm1_fn;
		logic start_go;
		logic event_assigned;
		logic [13:0] soak;
		logic [13:0] band;
		logic [26:0] tick_div;
		logic [11:0] sub_count;
		logic [13:0] elapsed;
		logic [26:0] blink_div;
		logic blink;
		logic run;
		logic end_flag;
		logic nvm_req;
		logic [15:0] nvm_count;
		logic [15:0] rdata;
		logic aux1;
		logic alarm1;
	} state_t;

	state_t cur;
	state_t nxt;

	logic in_band;
	logic [16:0] band_low;
	logic [16:0] band_high;
	logic [11:0] unit_len;
	logic [13:0] remain;

	// ==========================================================================
	// Helpers
	always_comb begin
		band_low = {1'b0, set_point} - {3'h0, cur.band};
		band_high = {1'b0, set_point} + {3'h0, cur.band};
		if (cur.band == 14'h0000) begin
			in_band = 1'b1; // R8
		end else begin
			// R7 R18
			in_band = ({1'b0, process_value} >= band_low || band_low[16])
				&& ({1'b0, process_value} <= band_high);
		end
		case (cur.unit)
			soak_program_pkg::UNIT_MINUTES: unit_len = 12'(`SECONDS_PER_MIN);
			soak_program_pkg::UNIT_HOURS: unit_len = 12'(`SECONDS_PER_HOUR);
			default: unit_len = 12'h001;
		endcase
		remain = (cur.elapsed >= cur.soak) ? 14'h0000 : cur.soak - cur.elapsed; // R20
	end

	// ==========================================================================
	// Next state
	always_comb begin
		logic start_req;
		logic reset_req;
		logic new_go;
		logic clear_req;
		start_req = 1'b0;
		reset_req = 1'b0;
		new_go = cur.start_go;
		clear_req = 1'b0;
		nxt = cur;
		nxt.nvm_req = 1'b0;
		nxt.ev_start_s = {cur.ev_start_s[1:0], event_start_pin};
		nxt.ev_clear_s = {cur.ev_clear_s[1:0], event_clear_pin};
		nxt.comm_s = {cur.comm_s[1:0], comm_start_pin};

		// Register writes.
		if (reg_write) begin
			case (reg_addr)
				`REG_PATTERN: begin
					if (reg_wdata[1:0] <= 2'h2) begin
						nxt.pattern = soak_program_pkg::program_pattern_select_t'(reg_wdata[1:0]);
						if (reg_wdata[1:0] == 2'h0 && cur.pattern != soak_program_pkg::PATTERN_OFF) begin
							nxt.event_assigned = 1'b0; // R11
							nxt.alarm1_fn = soak_program_pkg::OUT_FIRST_ALARM; // R14
						end
						if (reg_wdata[1:0] != 2'h0 && cur.pattern == soak_program_pkg::PATTERN_OFF) begin
							// R13
							nxt.aux1_fn = cooling_on_aux1 ? soak_program_pkg::OUT_COOLING
								: soak_program_pkg::OUT_END;
						end
					end
				end
				`REG_START: begin
					// A start setting with the pattern off is ignored and costs no memory write.
					if (!cur.event_assigned && cur.pattern != soak_program_pkg::PATTERN_OFF) begin
						new_go = reg_wdata[0]; // R3 R10 R16
					end
				end
				`REG_SOAK: begin
					if (reg_wdata[13:0] >= `SOAK_MIN && reg_wdata[13:0] <= `SOAK_MAX) begin
						nxt.soak = reg_wdata[13:0]; // R6
					end
				end
				`REG_UNIT: begin
					if (reg_wdata[1:0] <= 2'h2) begin
						nxt.unit = soak_program_pkg::soak_unit_t'(reg_wdata[1:0]);
					end
				end
				`REG_BAND: begin
					if (reg_wdata[13:0] <= `BAND_MAX) begin
						nxt.band = reg_wdata[13:0]; // R18
					end
				end
				`REG_ASSIGN: begin
					nxt.aux1_fn = soak_program_pkg::out_function_t'(reg_wdata[1:0]); // R19
					nxt.alarm1_fn = soak_program_pkg::out_function_t'(reg_wdata[3:2]);
					nxt.event_assigned = reg_wdata[4] && cur.pattern != soak_program_pkg::PATTERN_OFF;
				end
				default: begin
				end
			endcase
		end

		// Event and command start paths.
		if (cur.event_assigned) begin
			new_go = cur.ev_start_s[1]; // R9 R10
		end else if (cur.comm_s[1] && !cur.comm_s[2]
			&& cur.pattern != soak_program_pkg::PATTERN_OFF) begin
			new_go = 1'b1; // R9
		end
		if (cur.ev_clear_s[1] && !cur.ev_clear_s[2]) begin
			clear_req = 1'b1; // R16
		end

		start_req = new_go && !cur.start_go;
		reset_req = !new_go && cur.start_go;
		nxt.start_go = new_go;
		if (start_req || reset_req) begin
			nxt.nvm_req = 1'b1; // R17
			nxt.nvm_count = cur.nvm_count + 16'h0001;
		end

		// Sequencer.
		if (cur.pattern == soak_program_pkg::PATTERN_OFF) begin
			nxt.seq = soak_program_pkg::SEQ_IDLE; // R3
			nxt.end_flag = 1'b0;
		end else begin
			case (cur.seq)
				soak_program_pkg::SEQ_IDLE: begin
					if (start_req) begin
						nxt.seq = soak_program_pkg::SEQ_SOAK; // R1
						nxt.elapsed = 14'h0000;
						nxt.tick_div = 27'h0000000;
						nxt.sub_count = 12'h000;
						nxt.run = 1'b1;
					end
				end
				soak_program_pkg::SEQ_SOAK: begin
					if (reset_req) begin
						nxt.seq = soak_program_pkg::SEQ_IDLE;
						nxt.run = 1'b0;
					end else if (cur.elapsed >= cur.soak) begin
						nxt.seq = soak_program_pkg::SEQ_DONE; // R2
						nxt.end_flag = 1'b1;
						if (cur.pattern == soak_program_pkg::PATTERN_STOP) begin
							nxt.run = 1'b0; // R4
						end // R5: keep-running leaves run set.
					end else if (in_band) begin
						// R7
						if (cur.tick_div == SECOND_LAST) begin
							nxt.tick_div = 27'h0000000;
							if (cur.sub_count + 12'h001 >= unit_len) begin
								nxt.sub_count = 12'h000;
								nxt.elapsed = cur.elapsed + 14'h0001;
							end else begin
								nxt.sub_count = cur.sub_count + 12'h001;
							end
						end else begin
							nxt.tick_div = cur.tick_div + 27'h0000001;
						end
					end
				end
				soak_program_pkg::SEQ_DONE: begin
					if (reset_req || clear_req) begin
						nxt.seq = soak_program_pkg::SEQ_IDLE; // R15 R16
						nxt.end_flag = 1'b0;
					end
				end
				default: nxt.seq = soak_program_pkg::SEQ_IDLE;
			endcase
		end

		// Blink of the secondary display.
		if (cur.end_flag) begin
			if (cur.blink_div == BLINK_LAST) begin
				nxt.blink_div = 27'h0000000;
				nxt.blink = !cur.blink; // R12
			end else begin
				nxt.blink_div = cur.blink_div + 27'h0000001;
			end
		end else begin
			nxt.blink_div = 27'h0000000;
			nxt.blink = 1'b0;
		end

		// Output routing.
		nxt.aux1 = (cur.aux1_fn == soak_program_pkg::OUT_END) && cur.end_flag; // R19
		nxt.alarm1 = (cur.alarm1_fn == soak_program_pkg::OUT_END) && cur.end_flag;

		// Read data, valid in the cycle after the strobe.
		nxt.rdata = 16'h0000;
		if (reg_read) begin
			case (reg_addr)
				`REG_PATTERN: nxt.rdata = {14'h0000, cur.pattern};
				`REG_START: nxt.rdata = {15'h0000, cur.start_go};
				`REG_SOAK: nxt.rdata = {2'h0, cur.soak};
				`REG_UNIT: nxt.rdata = {14'h0000, cur.unit};
				`REG_BAND: nxt.rdata = {2'h0, cur.band};
				`REG_PROCESS: nxt.rdata = process_value;
				`REG_ASSIGN: nxt.rdata = {11'h000, cur.event_assigned, cur.alarm1_fn, cur.aux1_fn};
				`REG_STATUS: nxt.rdata = {12'h000, cur.blink, cur.seq == soak_program_pkg::SEQ_SOAK,
					cur.end_flag, cur.run}; // R19
				`REG_REMAIN: nxt.rdata = {2'h0, remain}; // R20
				`REG_WRITES: nxt.rdata = cur.nvm_count;
				default: nxt.rdata = 16'h0000;
			endcase
		end
	end

	// ==========================================================================
	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '{
				pattern: soak_program_pkg::PATTERN_OFF,
				unit: soak_program_pkg::UNIT_MINUTES,
				seq: soak_program_pkg::SEQ_IDLE,
				aux1_fn: soak_program_pkg::OUT_NONE,
				alarm1_fn: soak_program_pkg::OUT_FIRST_ALARM,
				soak: `SOAK_RESET,
				band: `BAND_RESET,
				default: '0
			};
		end else begin
			cur <= nxt;
		end
	end

	// The primary display always carries the process value; only the secondary is steered here.
	assign reg_rdata = cur.rdata;
	assign aux_out1 = cur.aux1;
	assign alarm_out1 = cur.alarm1;
	assign run_mode = cur.run;
	assign end_indication = cur.end_flag;
	assign show_end_on_secondary = cur.blink;
	assign nvm_write_req = cur.nvm_req;

endmodule

`default_nettype wire

//--- verif/soak_program_sequencer_assertions.sv
/*
 Port assertions of the soak program sequencer.
 Assumes binding to the design top; shadows software writes.
*/
`timescale 1ns/1ps
`default_nettype none
module soak_checker (
	// Clock, reset, register port
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	// Outputs
	input wire logic run_mode,
	input wire logic end_indication,
	input wire logic show_end_on_secondary,
	input wire logic nvm_write_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Shadows
	// A start write only counts when the pattern is on and no event owns it.
	logic [1:0] pat;
	logic evt;
	logic go;
	wire wr_start = reg_write && reg_addr == 4'h1;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pat <= 2'h0;
			evt <= 1'b0;
			go <= 1'b0;
		end else begin
			if (reg_write && reg_addr == 4'h0 && reg_wdata < 16'h0003)
				pat <= reg_wdata[1:0];
			if (reg_write && reg_addr == 4'h0 && reg_wdata == 16'h0000)
				evt <= 1'b0;
			else if (reg_write && reg_addr == 4'h6 && pat != 2'h0)
				evt <= reg_wdata[4];
			if (wr_start && !evt && pat != 2'h0)
				go <= reg_wdata[0];
		end
	end
	// ==========================================
	// Assertions
	sequence s_running;
		nvm_write_req && run_mode;
	endsequence
	sequence s_stopped;
		!run_mode && !end_indication;
	endsequence
	start_go_a: assert property (
		wr_start && reg_wdata[0] && !go && !evt && pat != 2'h0 |=> s_running)
		else $error("start write did not start a run");
	stop_clear_a: assert property (
		wr_start && !reg_wdata[0] && go && !evt |=> nvm_write_req ##[0:1] s_stopped)
		else $error("reset write did not stop and clear");
	off_idle_a: assert property (
		wr_start && pat == 2'h0 |=> !nvm_write_req && !run_mode)
		else $error("start acted while pattern off");
	evt_lock_a: assert property (
		wr_start && evt |=> !nvm_write_req)
		else $error("start write taken while event owns it");
	nvm_pulse_a: assert property (
		nvm_write_req |=> !nvm_write_req)
		else $error("memory write request too long");
	rdata_idle_a: assert property (
		!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	reset_quiet_a: assert property (
		$rose(rst_b) |-> !run_mode && !end_indication && !nvm_write_req)
		else $error("outputs not idle after reset");
	blink_end_a: assert property (
		$rose(show_end_on_secondary) |-> ##[0:2] end_indication)
		else $error("end alternation without end");
	end_run_a: assert property (
		$rose(end_indication) |-> $past(run_mode, 2) || $past(run_mode, 3))
		else $error("end raised without a run");
endmodule
bind soak_program_sequencer soak_checker u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .run_mode(run_mode), .end_indication(end_indication),
	.show_end_on_secondary(show_end_on_secondary), .nvm_write_req(nvm_write_req)
);
`default_nettype wire

//--- verif/field_side.sv
/*
 Far side model: event inputs, communications start, process values.
 Assumes the bench calls its tasks; pins change just after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module field_side (
	// Clock
	input wire logic core_clk,
	// Pins toward the sequencer
	output logic event_start_pin,
	output logic event_clear_pin,
	output logic comm_start_pin,
	output logic cooling_on_aux1,
	output logic [15:0] process_value,
	output logic [15:0] set_point
);
	initial begin
		event_start_pin = 1'b0;
		event_clear_pin = 1'b0;
		comm_start_pin = 1'b0;
		cooling_on_aux1 = 1'b0;
		process_value = 16'h0064;
		set_point = 16'h0064;
	end
	task automatic set_event(input logic v);
		@(posedge core_clk);
		event_start_pin <= v;
	endtask
	// Held for several cycles so the two-stage synchroniser cannot miss it.
	task automatic comm_pulse();
		@(posedge core_clk);
		comm_start_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		comm_start_pin <= 1'b0;
	endtask
	task automatic set_cool(input logic v);
		@(posedge core_clk);
		cooling_on_aux1 <= v;
	endtask
endmodule
`default_nettype wire

//--- verif/test_soak_program_sequencer.sv
/*
 Self-checking bench of the soak program sequencer.
 Assumes the design, its checker and the far side model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_soak_program_sequencer;
	logic core_clk;
	logic rst_b;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [15:0] reg_rdata;
	logic [15:0] process_value;
	logic [15:0] set_point;
	logic cooling_on_aux1;
	logic event_start_pin;
	logic event_clear_pin;
	logic comm_start_pin;
	logic aux_out1;
	logic alarm_out1;
	logic run_mode;
	logic end_indication;
	logic show_end_on_secondary;
	logic nvm_write_req;
	int num_errors;
	int n_tests;
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	soak_program_sequencer u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .process_value(process_value), .set_point(set_point),
		.cooling_on_aux1(cooling_on_aux1), .event_start_pin(event_start_pin),
		.event_clear_pin(event_clear_pin), .comm_start_pin(comm_start_pin),
		.aux_out1(aux_out1), .alarm_out1(alarm_out1), .run_mode(run_mode),
		.end_indication(end_indication), .show_end_on_secondary(show_end_on_secondary),
		.nvm_write_req(nvm_write_req)
	);
	field_side u_far (
		.core_clk(core_clk), .event_start_pin(event_start_pin),
		.event_clear_pin(event_clear_pin), .comm_start_pin(comm_start_pin),
		.cooling_on_aux1(cooling_on_aux1), .process_value(process_value),
		.set_point(set_point)
	);
	// ==========================================
	// Bus and compare
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] want);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		check(reg_rdata, want);
	endtask
	task automatic wait_sync();
		repeat (4) @(posedge core_clk);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_defaults();
		rchk(4'h0, 16'h0000);
		rchk(4'h2, 16'h0001);
		rchk(4'h4, 16'h0000);
		rchk(4'h6, 16'h0008);
		rchk(4'h7, 16'h0000);
		rchk(4'h8, 16'h0001);
		rchk(4'hF, 16'h0000);
	endtask
	task automatic t_off();
		wr(4'h1, 16'h0001);
		rchk(4'h7, 16'h0000);
		rchk(4'h9, 16'h0000);
		wr(4'h1, 16'h0000);
	endtask
	task automatic t_routing();
		u_far.set_cool(1'b1);
		wr(4'h0, 16'h0001);
		rchk(4'h6, 16'h000B);
		wr(4'h6, 16'h0015);
		wr(4'h0, 16'h0000);
		rchk(4'h6, 16'h0009);
		u_far.set_cool(1'b0);
		wr(4'h6, 16'h0008);
		wr(4'h0, 16'h0002);
		rchk(4'h6, 16'h0009);
	endtask
	task automatic t_limits();
		wr(4'h2, 16'h0000);
		wr(4'h2, 16'h2710);
		rchk(4'h2, 16'h0001);
		wr(4'h2, 16'h270F);
		rchk(4'h2, 16'h270F);
		rchk(4'h8, 16'h270F);
		wr(4'h3, 16'h0003);
		rchk(4'h3, 16'h0001);
		wr(4'h3, 16'h0000);
		rchk(4'h3, 16'h0000);
		wr(4'h4, 16'h2710);
		rchk(4'h4, 16'h0000);
		wr(4'h4, 16'h270F);
		rchk(4'h4, 16'h270F);
	endtask
	task automatic t_run();
		wr(4'h1, 16'h0001);
		rchk(4'h7, 16'h0005);
		rchk(4'h9, 16'h0001);
		check({12'h000, aux_out1, alarm_out1, end_indication, show_end_on_secondary}, 16'h0000);
		wr(4'h1, 16'h0000);
		rchk(4'h7, 16'h0000);
		rchk(4'h9, 16'h0002);
	endtask
	task automatic t_event();
		wr(4'h6, 16'h0019);
		wr(4'h1, 16'h0001);
		rchk(4'h7, 16'h0000);
		u_far.set_event(1'b1);
		wait_sync();
		rchk(4'h1, 16'h0001);
		rchk(4'h7, 16'h0005);
		u_far.set_event(1'b0);
		wait_sync();
		rchk(4'h7, 16'h0000);
		u_far.comm_pulse();
		wait_sync();
		rchk(4'h7, 16'h0000);
		wr(4'h0, 16'h0000);
		wr(4'h0, 16'h0002);
		u_far.comm_pulse();
		wait_sync();
		rchk(4'h7, 16'h0005);
	endtask
	task automatic t_midreset();
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		check({15'h0000, run_mode}, 16'h0000);
		rchk(4'h0, 16'h0000);
	endtask
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		num_errors = 0;
		n_tests = 0;
		rst_b = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_defaults();
		t_off();
		t_routing();
		t_limits();
		t_run();
		t_event();
		t_midreset();
		end_of_test();
	end
	// The whole run needs under 150 cycles; this span is far beyond it.
	initial begin
		#50000;
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
